/* include/csr_pkg.sv */
/*
 * Package for the shutdown and reset-entry control block: constants, bus
 * cycle types and packed carriers shared by the control and cache modules.
 * Assumes a single processor clock and an asynchronous active-high reset.
 */
// Operation
// - Severe error enters shutdown, stops execution
// - Shutdown halt cycle drives address bit low
// - Only NMI or reset leaves shutdown
// - Maskable interrupt ignored during shutdown
// - Fetch starts at power-up address after reset
// - Descriptor use writes accessed bit back
// - Task switch reloads segments, table, task
// - Cached descriptors change only on load or reload
package csr_pkg;
    localparam int ADDR_W      = 24;
    localparam int SEL_W       = 16;
    localparam int DESC_W      = 48;
    localparam int NUM_SEG     = 4;
    localparam int SEG_IDX_W   = 2;
    localparam int ACC_BIT     = 40;          // Accessed bit in access-rights byte
    localparam int DESC_WR_OFS = 5;           // Byte offset of access-rights byte
    localparam logic [ADDR_W-1:0] POWER_UP_ADDR = 24'hFFFFF0;
    localparam logic [ADDR_W-1:0] ZERO_ADDR     = 24'h000000;
    localparam logic [ADDR_W-1:0] HALT_ADDR_SHUT = 24'h000000; // Bit one low
    localparam logic [ADDR_W-1:0] HALT_ADDR_HLT  = 24'h000002; // Bit one high
    localparam logic [SEL_W-1:0]  ZERO_SEL      = 16'h0000;
    localparam logic [DESC_W-1:0] ZERO_DESC     = 48'h000000000000;

    typedef enum logic [2:0] {
        CSR_CYC_IDLE,
        CSR_CYC_FETCH,
        CSR_CYC_HALT,
        CSR_CYC_DESC_WR
    } csr_cyc_t;

    typedef struct packed {
        csr_cyc_t          kind;
        logic [ADDR_W-1:0] addr;
        logic [7:0]        data;
        logic              valid;
    } csr_bus_t;

    typedef struct packed {
        logic [SEL_W-1:0]  sel;
        logic [DESC_W-1:0] desc;
    } csr_seg_t;
endpackage : csr_pkg

/* src/csr_desc_cache.sv */
/*
 * Descriptor cache for segment, local table and task selector registers.
 * Assumes loads arrive one cycle wide from the control logic on ref_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module csr_desc_cache #(
    parameter int NUM_SEG = csr_pkg::NUM_SEG
) (
    // Clock and reset
    input  wire logic                        ref_clk,
    input  wire logic                        sys_rst,
    input  wire logic                        clkEn,
    // Single-register load
    input  wire logic                        loadSeg,
    input  wire logic [csr_pkg::SEG_IDX_W-1:0] loadIdx,
    input  wire logic                        loadLdt,
    input  wire logic                        loadTask,
    input  wire csr_pkg::csr_seg_t           loadVal,
    // Whole-context reload on task switch
    input  wire logic                        reloadAll,
    input  wire csr_pkg::csr_seg_t [NUM_SEG-1:0] newSeg,
    input  wire csr_pkg::csr_seg_t           newLdt,
    input  wire csr_pkg::csr_seg_t           newTask,
    // Cached contents
    output csr_pkg::csr_seg_t [NUM_SEG-1:0]  segCache,
    output csr_pkg::csr_seg_t                local_table_selector_reg,
    output csr_pkg::csr_seg_t                task_selector_reg
);
    csr_pkg::csr_seg_t [NUM_SEG-1:0] next_segCache;
    csr_pkg::csr_seg_t next_ldt;
    csr_pkg::csr_seg_t next_task;

    // Entries change only on an explicit load or reload; memory edits are never seen
    genvar g;
    generate
        for (g = 0; g < NUM_SEG; g++) begin : gSeg
            always_comb begin
                next_segCache[g] = segCache[g];
                if (reloadAll) begin
                    next_segCache[g] = newSeg[g];
                end else if (loadSeg && loadIdx == csr_pkg::SEG_IDX_W'(g)) begin
                    next_segCache[g] = loadVal;
                end
            end
        end
    endgenerate

    // Local table and task selector next values
    always_comb begin
        next_ldt  = local_table_selector_reg;
        next_task = task_selector_reg;
        if (reloadAll) begin
            next_ldt  = newLdt;
            next_task = newTask;
        end else begin
            if (loadLdt) next_ldt = loadVal;
            if (loadTask) next_task = loadVal;
        end
    end

    // Register state
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            segCache                 <= '0;
            local_table_selector_reg <= '0;
            task_selector_reg        <= '0;
        end else if (clkEn) begin
            segCache                 <= next_segCache;
            local_table_selector_reg <= next_ldt;
            task_selector_reg        <= next_task;
        end
    end
endmodule : csr_desc_cache
`default_nettype wire

/* src/csr_shutdown_ctrl.sv */
/*
 * Shutdown, halt and reset-entry control of the processor core.
 * Assumes pins nmiPin and maskable_interrupt_input come from outside the
 * clock domain; all other inputs come from core logic on ref_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module csr_shutdown_ctrl #(
    parameter int NUM_SEG = csr_pkg::NUM_SEG
) (
    // Clock, reset, enable
    input  wire logic                        ref_clk,
    input  wire logic                        sys_rst,
    input  wire logic                        clkEn,
    // External pins
    input  wire logic                        nmiPin,
    input  wire logic                        maskable_interrupt_input,
    // Core events
    input  wire logic                        severeError,
    input  wire logic                        halt_instruction,
    input  wire logic                        intEnable,
    input  wire logic                        descUse,
    input  wire logic [csr_pkg::ADDR_W-1:0]  descAddr,
    input  wire logic [7:0]                  descRights,
    input  wire logic                        busDone,
    // Descriptor loads
    input  wire logic                        loadSeg,
    input  wire logic [csr_pkg::SEG_IDX_W-1:0] loadIdx,
    input  wire logic                        loadLdt,
    input  wire logic                        loadTask,
    input  wire csr_pkg::csr_seg_t           loadVal,
    input  wire logic                        taskSwitch,
    input  wire csr_pkg::csr_seg_t [NUM_SEG-1:0] newSeg,
    input  wire csr_pkg::csr_seg_t           newLdt,
    input  wire csr_pkg::csr_seg_t           newTask,
    // Bus cycle request
    output csr_pkg::csr_bus_t                busReq,
    output logic                             address_bit_one,
    // Core status
    output logic                             running,
    output logic                             inShutdown,
    output logic                             inHalt,
    output logic                             nmiTaken,
    output logic                             intTaken,
    // Cached descriptors
    output csr_pkg::csr_seg_t [NUM_SEG-1:0]  segCache,
    output csr_pkg::csr_seg_t                local_table_selector_reg,
    output csr_pkg::csr_seg_t                task_selector_reg
);
    typedef enum logic [2:0] {
        ST_RESET_FETCH,
        ST_RUN,
        ST_HALT_CYC,
        ST_HALTED,
        ST_SHUT_CYC,
        ST_SHUTDOWN,
        ST_DESC_WR
    } csr_state_t;

    csr_state_t        state;
    csr_state_t        next_state;
    csr_pkg::csr_bus_t next_busReq;
    logic              next_addrBit;
    logic              next_nmiTaken;
    logic              next_intTaken;
    logic [2:0]        nmiSync;
    logic [2:0]        intSync;
    logic              nmiLvl;
    logic              intLvl;
    logic              nmiPrev;
    logic              next_nmiLvl;
    logic              next_intLvl;
    logic              nmiEdge;

    // Three-stage pin synchronisers; level follows once stages two and three agree
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            nmiSync <= 3'h0;
            intSync <= 3'h0;
        end else if (clkEn) begin
            nmiSync <= {nmiSync[1:0], nmiPin};
            intSync <= {intSync[1:0], maskable_interrupt_input};
        end
    end

    // Filtered pin levels
    always_comb begin
        next_nmiLvl = (nmiSync[1] == nmiSync[2]) ? nmiSync[2] : nmiLvl;
        next_intLvl = (intSync[1] == intSync[2]) ? intSync[2] : intLvl;
    end

    assign nmiEdge = nmiLvl && !nmiPrev; // NMI is edge triggered

    // Control sequence next values
    always_comb begin
        next_state    = state;
        next_busReq   = '0;
        next_addrBit  = address_bit_one;
        next_nmiTaken = 1'b0;
        next_intTaken = 1'b0;
        unique case (state)
            ST_RESET_FETCH: begin
                next_busReq.kind  = csr_pkg::CSR_CYC_FETCH;
                next_busReq.addr  = csr_pkg::POWER_UP_ADDR;
                next_busReq.valid = 1'b1;
                if (busDone) next_state = ST_RUN;
            end
            ST_RUN: begin
                if (severeError) begin
                    next_state = ST_SHUT_CYC;
                end else if (nmiEdge) begin
                    next_nmiTaken = 1'b1;
                end else if (halt_instruction) begin
                    next_state = ST_HALT_CYC;
                end else if (descUse) begin
                    next_state = ST_DESC_WR;
                end else if (intLvl && intEnable) begin
                    next_intTaken = 1'b1;
                end
            end
            ST_DESC_WR: begin
                next_busReq.kind  = csr_pkg::CSR_CYC_DESC_WR;
                next_busReq.addr  = descAddr + csr_pkg::ADDR_W'(csr_pkg::DESC_WR_OFS);
                next_busReq.data  = descRights | 8'h01;
                next_busReq.valid = 1'b1;
                if (severeError) next_state = ST_SHUT_CYC;
                else if (busDone) next_state = ST_RUN;
            end
            ST_HALT_CYC: begin
                next_busReq.kind  = csr_pkg::CSR_CYC_HALT;
                next_busReq.addr  = csr_pkg::HALT_ADDR_HLT;
                next_busReq.valid = 1'b1;
                next_addrBit      = 1'b1;
                if (busDone) next_state = ST_HALTED;
            end
            ST_HALTED: begin
                if (nmiEdge) begin
                    next_nmiTaken = 1'b1;
                    next_state    = ST_RUN;
                end else if (intLvl && intEnable) begin
                    next_intTaken = 1'b1;
                    next_state    = ST_RUN;
                end
            end
            ST_SHUT_CYC: begin
                next_busReq.kind  = csr_pkg::CSR_CYC_HALT;
                next_busReq.addr  = csr_pkg::HALT_ADDR_SHUT;
                next_busReq.valid = 1'b1;
                next_addrBit      = 1'b0;
                if (busDone) next_state = ST_SHUTDOWN;
            end
            ST_SHUTDOWN: begin
                // Maskable interrupt requests are never looked at here
                if (nmiEdge) begin
                    next_nmiTaken = 1'b1;
                    next_state    = ST_RUN;
                end
            end
        endcase
        if (taskSwitch && state != ST_SHUTDOWN && state != ST_SHUT_CYC) begin
            next_state = next_state; // Reload happens in the cache
        end
    end

    // Register control state; reset forces the power-up fetch
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state           <= ST_RESET_FETCH;
            busReq          <= '0;
            address_bit_one <= 1'b0;
            running         <= 1'b0;
            inShutdown      <= 1'b0;
            inHalt          <= 1'b0;
            nmiTaken        <= 1'b0;
            intTaken        <= 1'b0;
            nmiLvl          <= 1'b0;
            intLvl          <= 1'b0;
            nmiPrev         <= 1'b0;
        end else if (clkEn) begin
            state           <= next_state;
            busReq          <= next_busReq;
            address_bit_one <= next_addrBit;
            running         <= (next_state == ST_RUN) || (next_state == ST_DESC_WR);
            inShutdown      <= (next_state == ST_SHUTDOWN) || (next_state == ST_SHUT_CYC);
            inHalt          <= (next_state == ST_HALTED) || (next_state == ST_HALT_CYC);
            nmiTaken        <= next_nmiTaken;
            intTaken        <= next_intTaken;
            nmiLvl          <= next_nmiLvl;
            intLvl          <= next_intLvl;
            nmiPrev         <= nmiLvl;
        end
    end

    // Descriptor caches, blocked during shutdown
    csr_desc_cache #(
        .NUM_SEG (NUM_SEG)
    ) uCache (
        .ref_clk                  (ref_clk),
        .sys_rst                  (sys_rst),
        .clkEn                    (clkEn),
        .loadSeg                  (loadSeg && running),
        .loadIdx                  (loadIdx),
        .loadLdt                  (loadLdt && running),
        .loadTask                 (loadTask && running),
        .loadVal                  (loadVal),
        .reloadAll                (taskSwitch && !inShutdown),
        .newSeg                   (newSeg),
        .newLdt                   (newLdt),
        .newTask                  (newTask),
        .segCache                 (segCache),
        .local_table_selector_reg (local_table_selector_reg),
        .task_selector_reg        (task_selector_reg)
    );
endmodule : csr_shutdown_ctrl
`default_nettype wire

/* testbench/cpu_shutdown_and_reset_entry_test.sv */
/* Self-checking bench for the shutdown and reset-entry control.
   Assumes the bus model and checker files compile before this one. */
`timescale 1ns/1ps
`default_nettype none
module cpu_shutdown_and_reset_entry_test;
    logic ref_clk = 1'b0, sys_rst = 1'b1, clkEn = 1'b1, nmiPin = 1'b0, maskable_interrupt_input = 1'b0;
    logic severeError = 1'b0, halt_instruction = 1'b0, intEnable = 1'b0, descUse = 1'b0, busDone;
    logic loadSeg = 1'b0, loadLdt = 1'b0, loadTask = 1'b0, taskSwitch = 1'b0, seen;
    logic [23:0] descAddr = 24'h000000;
    logic [7:0] descRights = 8'h00;
    logic [1:0] loadIdx = 2'h0;
    logic [3:0] lat = 4'h0;
    csr_pkg::csr_seg_t loadVal = 64'h1234_0000_5678_9ABC, newLdt = 64'h0028_0000_8200_0000;
    csr_pkg::csr_seg_t newTask = 64'h0030_0000_8B00_0100, local_table_selector_reg, task_selector_reg;
    csr_pkg::csr_seg_t [3:0] newSeg = {4{64'hA008_00C0_9300_0000}}, segCache;
    csr_pkg::csr_bus_t busReq;
    logic address_bit_one, running, inShutdown, inHalt, nmiTaken, intTaken;
    int err_count = 0;
    int n_checks = 0;
    // Clock, design, bus controller
    always #4 ref_clk = ~ref_clk;
    csr_shutdown_ctrl uut (.ref_clk, .sys_rst, .clkEn, .nmiPin, .maskable_interrupt_input, .severeError,
        .halt_instruction, .intEnable, .descUse, .descAddr, .descRights, .busDone, .loadSeg, .loadIdx,
        .loadLdt, .loadTask, .loadVal, .taskSwitch, .newSeg, .newLdt, .newTask, .busReq, .address_bit_one,
        .running, .inShutdown, .inHalt, .nmiTaken, .intTaken, .segCache, .local_table_selector_reg,
        .task_selector_reg);
    csr_bus_model u_bus (.ref_clk, .sys_rst, .busReq, .lat, .busDone);
    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // First cycle after reset, then run
    task automatic t_reset_entry;
        for (int i = 0; i < 10 && busReq.valid !== 1'b1; i++) @(negedge ref_clk);
        chk("fetch", 64'({csr_pkg::CSR_CYC_FETCH, csr_pkg::POWER_UP_ADDR}), 64'({busReq.kind, busReq.addr}));
        for (int i = 0; i < 20 && running !== 1'b1; i++) @(negedge ref_clk);
        chk("running", 64'h1, 64'(running));
    endtask : t_reset_entry
    // Halt instruction with a slow bus, resumed by an enabled interrupt
    task automatic t_halt;
        lat = 4'h3;
        @(negedge ref_clk) halt_instruction = 1'b1;
        @(negedge ref_clk) halt_instruction = 1'b0;
        for (int i = 0; i < 10 && busReq.valid !== 1'b1; i++) @(negedge ref_clk);
        chk("halt", 64'({csr_pkg::CSR_CYC_HALT, csr_pkg::HALT_ADDR_HLT, 2'h3}),
            64'({busReq.kind, busReq.addr, address_bit_one, inHalt}));
        repeat (8) @(negedge ref_clk);
        intEnable = 1'b1;
        maskable_interrupt_input = 1'b1;
        for (int i = 0; i < 20 && running !== 1'b1; i++) @(negedge ref_clk);
        maskable_interrupt_input = 1'b0;
        intEnable = 1'b0;
        chk("resume", 64'h1, 64'(running));
        lat = 4'h0;
    endtask : t_halt
    // Descriptor use near a 64 KB boundary
    task automatic t_desc;
        descAddr = 24'h00FFFB;
        descRights = 8'h92;
        @(negedge ref_clk) descUse = 1'b1;
        @(negedge ref_clk) descUse = 1'b0;
        for (int i = 0; i < 10 && busReq.kind !== csr_pkg::CSR_CYC_DESC_WR; i++) @(negedge ref_clk);
        chk("desc write", 64'({24'h010000, 8'h93}), 64'({busReq.addr, busReq.data}));
        repeat (4) @(negedge ref_clk);
    endtask : t_desc
    // Single loads, then whole reload on a task switch
    task automatic t_cache;
        loadIdx = 2'h2;
        // Enable low: a load must not land
        @(negedge ref_clk) {clkEn, loadSeg} = 2'h1;
        @(negedge ref_clk) {clkEn, loadSeg} = 2'h2;
        chk("frozen seg2", 64'h0, 64'(segCache[2]));
        @(negedge ref_clk) {loadSeg, loadLdt, loadTask} = 3'h7;
        @(negedge ref_clk) {loadSeg, loadLdt, loadTask} = 3'h0;
        repeat (3) @(negedge ref_clk);
        chk("seg2", 64'(loadVal), 64'(segCache[2]));
        chk("seg1", 64'h0, 64'(segCache[1]));
        chk("ldt load", 64'(loadVal), 64'(local_table_selector_reg));
        chk("task load", 64'(loadVal), 64'(task_selector_reg));
        @(negedge ref_clk) taskSwitch = 1'b1;
        @(negedge ref_clk) taskSwitch = 1'b0;
        repeat (3) @(negedge ref_clk);
        for (int k = 0; k < 4; k++) chk("seg reload", 64'(newSeg[k]), 64'(segCache[k]));
        chk("ldt reload", 64'(newLdt), 64'(local_table_selector_reg));
        chk("task reload", 64'(newTask), 64'(task_selector_reg));
    endtask : t_cache
    // Shutdown: interrupt and halt ignored, nmi leaves
    task automatic t_shutdown;
        @(negedge ref_clk) severeError = 1'b1;
        @(negedge ref_clk) severeError = 1'b0;
        for (int i = 0; i < 10 && busReq.valid !== 1'b1; i++) @(negedge ref_clk);
        chk("shutdown", 64'({csr_pkg::CSR_CYC_HALT, csr_pkg::HALT_ADDR_SHUT, 3'h1}),
            64'({busReq.kind, busReq.addr, address_bit_one, running, inShutdown}));
        seen = 1'b0;
        {intEnable, maskable_interrupt_input, halt_instruction} = 3'h7;
        for (int i = 0; i < 20; i++) @(negedge ref_clk) seen = seen | intTaken | running;
        {intEnable, maskable_interrupt_input, halt_instruction} = 3'h0;
        chk("int ignored", 64'h0, 64'(seen));
        chk("still shut", 64'h1, 64'(inShutdown));
        nmiPin = 1'b1;
        seen = 1'b0;
        for (int i = 0; i < 20 && running !== 1'b1; i++) @(negedge ref_clk) seen = seen | nmiTaken;
        nmiPin = 1'b0;
        chk("nmi exit", 64'h5, 64'({running, inShutdown, seen}));
    endtask : t_shutdown
    // Reset also ends shutdown and restarts at the power-up address
    task automatic t_reset_exit;
        @(negedge ref_clk) severeError = 1'b1;
        @(negedge ref_clk) severeError = 1'b0;
        for (int i = 0; i < 10 && inShutdown !== 1'b1; i++) @(negedge ref_clk);
        sys_rst = 1'b1;
        @(negedge ref_clk);
        chk("reset exit", 64'h0, 64'({inShutdown, running}));
        sys_rst = 1'b0;
        t_reset_entry();
    endtask : t_reset_exit
    task automatic end_sim;
        if (err_count == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_sim
    // Main sequence
    initial begin
        repeat (5) @(negedge ref_clk);
        sys_rst = 1'b0;
        t_reset_entry();
        t_cache();
        t_desc();
        t_halt();
        t_shutdown();
        t_reset_exit();
        end_sim();
    end
    // Watchdog far beyond the hundred or so cycles the tests need
    initial begin
        #40000;
        err_count++;
        end_sim();
    end
endmodule : cpu_shutdown_and_reset_entry_test
bind csr_shutdown_ctrl csr_shutdown_assertions #(.NUM_SEG(NUM_SEG)) u_chk (.ref_clk, .sys_rst, .nmiPin,
    .busDone, .loadSeg, .loadLdt, .loadTask, .taskSwitch, .newTask, .busReq, .address_bit_one, .running,
    .inShutdown, .inHalt, .intTaken, .segCache, .local_table_selector_reg, .task_selector_reg);
`default_nettype wire

/* testbench/csr_bus_model.sv */
/* Bus controller model: completes each requested cycle after lat waits.
   Drives busDone on the falling edge of ref_clk, one cycle wide. */
`timescale 1ns/1ps
`default_nettype none
module csr_bus_model (
    // Clock and reset
    input  wire logic              ref_clk,
    input  wire logic              sys_rst,
    // Cycle request and completion
    input  wire csr_pkg::csr_bus_t busReq,
    input  wire logic [3:0]        lat,
    output logic                   busDone
);
    logic [3:0] waitCnt;
    // Count wait states, then pulse completion
    always_ff @(negedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            waitCnt <= 4'h0;
            busDone <= 1'b0;
        end else begin
            busDone <= busReq.valid && !busDone && waitCnt >= lat;
            waitCnt <= (busReq.valid && !busDone && waitCnt < lat) ? waitCnt + 4'h1 : 4'h0;
        end
    end
endmodule : csr_bus_model
`default_nettype wire

/* testbench/csr_shutdown_assertions.sv */
/* Checker for the shutdown, halt and reset-entry control.
   Bound to csr_shutdown_ctrl; one clock ref_clk, async reset sys_rst. */
`timescale 1ns/1ps
`default_nettype none
module csr_shutdown_assertions #(
    parameter int NUM_SEG = 4
) (
    // Clock and reset
    input wire logic                             ref_clk,
    input wire logic                             sys_rst,
    // Inputs watched
    input wire logic                             nmiPin,
    input wire logic                             busDone,
    input wire logic                             loadSeg,
    input wire logic                             loadLdt,
    input wire logic                             loadTask,
    input wire logic                             taskSwitch,
    input wire csr_pkg::csr_seg_t                newTask,
    // Outputs watched
    input wire csr_pkg::csr_bus_t                busReq,
    input wire logic                             address_bit_one,
    input wire logic                             running,
    input wire logic                             inShutdown,
    input wire logic                             inHalt,
    input wire logic                             intTaken,
    input wire csr_pkg::csr_seg_t [NUM_SEG-1:0]  segCache,
    input wire csr_pkg::csr_seg_t                local_table_selector_reg,
    input wire csr_pkg::csr_seg_t                task_selector_reg
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // Halt-type cycles and their address bit
    // The cycle request follows one edge after the state flag
    chk_shut_cycle: assert property ($rose(inShutdown) |=> busReq.valid &&
        busReq.kind == csr_pkg::CSR_CYC_HALT && busReq.addr == csr_pkg::HALT_ADDR_SHUT && !address_bit_one)
        else $error("shutdown cycle wrong");
    chk_halt_cycle: assert property ($rose(inHalt) |=> busReq.valid &&
        busReq.kind == csr_pkg::CSR_CYC_HALT && busReq.addr == csr_pkg::HALT_ADDR_HLT && address_bit_one)
        else $error("halt cycle wrong");
    // Request stands one edge past completion, so that trailing cycle is exempt
    chk_cycle_hold: assert property (busReq.valid && !busDone && !$past(busDone) |=> $stable(busReq))
        else $error("bus cycle changed before done");
    // Shutdown state
    chk_shut_stopped: assert property (inShutdown |-> !running)
        else $error("running in shutdown");
    chk_shut_stays: assert property ((inShutdown && !nmiPin) [*8] |=> inShutdown)
        else $error("left shutdown without nmi");
    chk_int_ignored: assert property (inShutdown && $past(inShutdown) |-> !intTaken)
        else $error("interrupt taken in shutdown");
    // Reset entry and descriptor write
    chk_reset_fetch: assert property ($past(sys_rst) && !sys_rst |=> busReq.valid &&
        busReq.kind == csr_pkg::CSR_CYC_FETCH && busReq.addr == csr_pkg::POWER_UP_ADDR)
        else $error("no fetch at power-up address");
    chk_desc_acc: assert property (busReq.valid && busReq.kind == csr_pkg::CSR_CYC_DESC_WR |-> busReq.data[0])
        else $error("accessed bit not set");
    // Descriptor caches
    chk_seg_stable: assert property (!$past(loadSeg) && !$past(loadSeg, 2) && !$past(taskSwitch) &&
        !$past(taskSwitch, 2) |-> $stable(segCache)) else $error("segment cache changed");
    chk_tbl_stable: assert property (!$past(loadLdt) && !$past(loadLdt, 2) && !$past(loadTask) &&
        !$past(loadTask, 2) && !$past(taskSwitch) && !$past(taskSwitch, 2) |->
        $stable(local_table_selector_reg) && $stable(task_selector_reg)) else $error("table cache changed");
    chk_task_reload: assert property (taskSwitch && !inShutdown |-> ##[1:3] task_selector_reg == newTask)
        else $error("task register not reloaded");
    // Main scenarios
    cov_shut: cover property ($rose(inShutdown));
    cov_halt: cover property ($rose(inHalt));
    cov_leave: cover property ($fell(inShutdown));
endmodule : csr_shutdown_assertions
`default_nettype wire
